// file: rtl/fnd_core.sv
// Fractional-N feedback divider control core
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Ratio is whole plus numerator over denominator
// - Whole value from word 0 bits 30:15
// - Numerator from word 0 bits 14:3
// - Denominator word 1 bits 14:3, host-limited
// - Word 7 upper bits widen to sixteen
// - Zero numerator gives integer-only ratio
// - Detector rate from reference, doubler, pre-divider
// - Divide-by-two doubles effective pre-division
// - Doubler doubles detector frequency
// - Band divider eight bits, four upper extension
// - Lock window from three select bits
// - Undithered repeat length follows denominator factors
// - Dither gives repeat length two to 21
// - Phase detector, second edge clears both outputs, no overlap
// - Band select at power-up and word 0
// - Skip bit suppresses word 0 band select, resync
module fnd_core
  import fnd_pkg::*;
(
  input wire logic mclk, // Detector-rate clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic [31:0] word0, // Configuration word 0
  input wire logic word0_wr, // Word 0 written pulse
  input wire logic [31:0] word1, // Configuration word 1
  input wire logic [31:0] word2, // Configuration word 2
  input wire logic [31:0] word4, // Configuration word 4
  input wire logic [31:0] word6, // Configuration word 6
  input wire logic ext_en, // Word 7 extension active
  input wire logic [3:0] num_upper, // Numerator upper bits
  input wire logic [3:0] denominator_upper_bits, // Denominator upper bits
  input wire logic [9:0] ref_div, // Reference pre-divider
  input wire logic ref_half, // Reference divide-by-two
  input wire logic doubler_en, // Reference doubler enable
  input wire logic dither_en, // Modulator dither enable
  input wire logic ref_edge, // Reference counter pulse, async
  input wire logic fb_edge, // Feedback counter pulse, async
  input wire logic resync_en, // Phase resync enabled
  output logic [15:0] fb_div, // Instantaneous feedback divide
  output logic int_mode, // Integer-only mode
  output logic [11:0] band_div, // Band clock divider
  output logic [7:0] lock_window, // Lock window, tenths of ns
  output logic [10:0] pre_div, // Effective pre-division
  output logic ref_mult, // Reference multiplier minus one
  output logic [23:0] repeat_len, // Modulator repeat length
  output logic band_busy, // Band selection running
  output logic resync_req, // Resync request pulse
  output logic pd_up, // Detector up output
  output logic pd_dn // Detector down output
);
  import fnd_pkg::*;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  fnd_ratio_t ratio;
  logic lock_window_base_sel;
  logic lock_window_mid_sel;
  logic lock_window_hi_sel;
  logic [3:0] band_clock_div_upper;
  logic skip_cal;
  // Word fields and widened numerator and denominator
  always_comb begin
    ratio.whole = word0[WHOLE_LSB +: WHOLE_W];
    ratio.num = {ext_en ? num_upper : 4'h0,
                 word0[FRAC_LSB +: FRAC_W]};
    ratio.den = {ext_en ? denominator_upper_bits : 4'h0,
                 word1[FRAC_LSB +: FRAC_W]};
    lock_window_base_sel = word2[LOCK_BASE_BIT];
    lock_window_mid_sel = word6[LOCK_MID_BIT];
    lock_window_hi_sel = word6[LOCK_HI_BIT];
    band_clock_div_upper = word6[BAND_EXT_LSB +: BAND_EXT_W];
    skip_cal = word1[SKIP_CAL_BIT];
  end

  // ----------------------------------------
  // Synchronisers for detector inputs
  // ----------------------------------------
  logic [1:0] ref_sync;
  logic [1:0] fb_sync;
  logic ref_last;
  logic fb_last;
  logic [1:0] next_ref_sync;
  logic [1:0] next_fb_sync;
  logic next_ref_last;
  logic next_fb_last;
  logic ref_rise;
  logic fb_rise;
  // Shift pins in; edge detect on second stage only
  always_comb begin
    next_ref_sync = {ref_sync[0], ref_edge};
    next_fb_sync = {fb_sync[0], fb_edge};
    next_ref_last = ref_sync[1];
    next_fb_last = fb_sync[1];
    ref_rise = ref_sync[1] & ~ref_last;
    fb_rise = fb_sync[1] & ~fb_last;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_sync <= 2'h0;
      fb_sync <= 2'h0;
      ref_last <= 1'b0;
      fb_last <= 1'b0;
    end else if (ce) begin
      ref_sync <= next_ref_sync;
      fb_sync <= next_fb_sync;
      ref_last <= next_ref_last;
      fb_last <= next_fb_last;
    end
  end

  // ----------------------------------------
  // Phase-frequency detector
  // ----------------------------------------
  logic next_pd_up;
  logic next_pd_dn;
  // Set on edges; the second edge clears both in the same cycle, so both are never up together
  always_comb begin
    next_pd_up = pd_up | ref_rise;
    next_pd_dn = pd_dn | fb_rise;
    if (next_pd_up && next_pd_dn) begin
      next_pd_up = 1'b0;
      next_pd_dn = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pd_up <= 1'b0;
      pd_dn <= 1'b0;
    end else if (ce) begin
      pd_up <= next_pd_up;
      pd_dn <= next_pd_dn;
    end
  end

  // ----------------------------------------
  // Sigma-delta modulator, first order
  // ----------------------------------------
  logic [16:0] acc;
  logic [16:0] next_acc;
  logic [22:0] lfsr;
  logic [22:0] next_lfsr;
  logic carry;
  logic [15:0] next_fb_div;
  logic [16:0] sum;
  // Accumulate numerator modulo denominator, dithered LSB
  always_comb begin
    next_lfsr = {lfsr[21:0], lfsr[20] ^ lfsr[17]};
    sum = acc + {1'b0, ratio.num} +
          {16'h0000, dither_en & lfsr[0] & ~int_mode};
    carry = (sum >= {1'b0, ratio.den});
    next_acc = carry ? sum - {1'b0, ratio.den} : sum;
    if (int_mode) begin
      next_acc = 17'h0_0000;
    end
    next_fb_div = ratio.whole + {15'h0000, carry & ~int_mode};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc <= 17'h0_0000;
      lfsr <= 23'h00_0001;
      fb_div <= WHOLE_RST;
    end else if (ce) begin
      acc <= next_acc;
      lfsr <= next_lfsr;
      fb_div <= next_fb_div;
    end
  end

  // ----------------------------------------
  // Static settings
  // ----------------------------------------
  logic [7:0] next_lock_window;
  logic [23:0] next_repeat_len;
  logic div2;
  logic div3;
  // Window table and repeat length
  always_comb begin
    case ({lock_window_hi_sel, lock_window_mid_sel,
           lock_window_base_sel})
      3'h0: next_lock_window = LW_10_0;
      3'h1: next_lock_window = LW_6_0;
      3'h2, 3'h3: next_lock_window = LW_3_0;
      3'h4: next_lock_window = LW_4_0;
      3'h5: next_lock_window = LW_4_5;
      default: next_lock_window = LW_1_5;
    endcase
    div2 = ~ratio.den[0];
    div3 = (ratio.den % 16'h0003) == 16'h0000;
    if (dither_en) begin
      next_repeat_len = 24'h1 << DITHER_LEN_LOG2;
    end else if (div2 && div3) begin
      next_repeat_len = {8'h00, ratio.den} * 24'h6;
    end else if (div3) begin
      next_repeat_len = {8'h00, ratio.den} * 24'h3;
    end else if (div2) begin
      next_repeat_len = {8'h00, ratio.den} * 24'h2;
    end else begin
      next_repeat_len = {8'h00, ratio.den};
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_mode <= 1'b1;
      band_div <= 12'h000;
      lock_window <= LW_10_0;
      pre_div <= {1'b0, REFDIV_RST};
      ref_mult <= 1'b0;
      repeat_len <= {8'h00, DEN_RST};
    end else if (ce) begin
      int_mode <= (ratio.num == 16'h0000);
      band_div <= {band_clock_div_upper,
                   word4[BAND_LSB +: BAND_W]};
      lock_window <= next_lock_window;
      pre_div <= ref_half ? {ref_div, 1'b0}
                          : {1'b0, ref_div};
      ref_mult <= doubler_en;
      repeat_len <= next_repeat_len;
    end
  end

  // ----------------------------------------
  // Band selection sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {FND_IDLE, FND_BAND} fnd_state_t;
  fnd_state_t state;
  fnd_state_t next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic next_resync_req;
  // Run at power-up and on word 0 unless skipped
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_resync_req = 1'b0;
    case (state)
      FND_IDLE: begin
        if (word0_wr && !skip_cal) begin
          next_state = FND_BAND;
          next_cnt = BAND_CYCLES;
        end
      end
      FND_BAND: begin
        if (cnt == 12'h001) begin
          next_state = FND_IDLE;
          next_resync_req = resync_en;
        end
        next_cnt = cnt - 12'h001;
      end
      default: next_state = FND_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= FND_BAND;
      cnt <= BAND_CYCLES;
      resync_req <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      resync_req <= next_resync_req;
    end
  end
  assign band_busy = (state == FND_BAND);
endmodule
`default_nettype wire

// file: rtl/fnd_pkg.sv
// Package for the fractional-N divider control block
package fnd_pkg;
  // ----------------------------------------
  // Field positions in configuration words
  // ----------------------------------------
  localparam int WHOLE_LSB = 15;
  localparam int WHOLE_W = 16;
  localparam int FRAC_LSB = 3;
  localparam int FRAC_W = 12;
  localparam int SKIP_CAL_BIT = 28;
  localparam int BAND_LSB = 3;
  localparam int BAND_W = 8;
  localparam int BAND_EXT_LSB = 3;
  localparam int BAND_EXT_W = 4;
  localparam int LOCK_BASE_BIT = 7;
  localparam int LOCK_MID_BIT = 26;
  localparam int LOCK_HI_BIT = 27;
  localparam int REFDIV_W = 10;
  // ----------------------------------------
  // Reset values and timing counts
  // ----------------------------------------
  localparam logic [15:0] WHOLE_RST = 16'h0000;
  localparam logic [15:0] DEN_RST = 16'h0002;
  localparam logic [9:0] REFDIV_RST = 10'h001;
  localparam int DITHER_LEN_LOG2 = 21;
  localparam logic [11:0] BAND_CYCLES = 12'h040;
  // Lock window codes, in tenths of a nanosecond
  localparam logic [7:0] LW_10_0 = 8'h64;
  localparam logic [7:0] LW_6_0 = 8'h3C;
  localparam logic [7:0] LW_3_0 = 8'h1E;
  localparam logic [7:0] LW_4_0 = 8'h28;
  localparam logic [7:0] LW_4_5 = 8'h2D;
  localparam logic [7:0] LW_1_5 = 8'h0F;

  // Divider settings carried together
  typedef struct packed {
    logic [15:0] whole;
    logic [15:0] num;
    logic [15:0] den;
  } fnd_ratio_t;
endpackage

// file: testbench/fnd_core_properties.sv
// Checker of the divider control block
`timescale 1ns/1ps
`default_nettype none
module fnd_core_chk
  import fnd_pkg::*;
(
  input wire logic mclk, rst, word0_wr, ext_en, ref_half, doubler_en,
  input wire logic ref_edge, resync_en, int_mode, ref_mult,
  input wire logic band_busy, resync_req, pd_up, pd_dn,
  input wire logic [31:0] word0, word1, word2, word6,
  input wire logic [3:0] num_upper,
  input wire logic [9:0] ref_div,
  input wire logic [15:0] fb_div,
  input wire logic [7:0] lock_window,
  input wire logic [10:0] pre_div
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Window code to tenths of a nanosecond
  function automatic logic [7:0] lw(input logic [2:0] c);
    case (c)
      3'h0: lw = LW_10_0;
      3'h1: lw = LW_6_0;
      3'h2, 3'h3: lw = LW_3_0;
      3'h4: lw = LW_4_0;
      3'h5: lw = LW_4_5;
      default: lw = LW_1_5;
    endcase
  endfunction
  // ----------------------------------------
  // Band select steps
  // ----------------------------------------
  sequence band_go;
    !band_busy && word0_wr && !word1[SKIP_CAL_BIT];
  endsequence
  sequence band_run;
    band_busy ##63 band_busy ##1 (!band_busy && resync_req == resync_en);
  endsequence
  band_run_a: assert property (band_go |=> band_run)
    else $error("band select length wrong");
  band_skip_a: assert property (
    !band_busy && word0_wr && word1[SKIP_CAL_BIT] |=> !band_busy)
    else $error("band select ran with skip set");
  resync_one_a: assert property (
    !band_busy && $past(!band_busy) |-> !resync_req)
    else $error("stray resync request");
  // ----------------------------------------
  // Settings
  // ----------------------------------------
  int_only_a: assert property (
    !$past(rst) && int_mode |-> fb_div == $past(word0[30:15]))
    else $error("integer divide wrong");
  int_mode_a: assert property (!$past(rst) |-> int_mode ==
    ($past(word0[14:3]) == 0 && !($past(ext_en) && $past(num_upper) != 0)))
    else $error("integer mode flag wrong");
  pre_div_a: assert property (!$past(rst) |-> pre_div ==
    ($past(ref_half) ? {$past(ref_div), 1'b0} : {1'b0, $past(ref_div)}))
    else $error("pre-division wrong");
  ref_mult_a: assert property (
    !$past(rst) |-> ref_mult == $past(doubler_en))
    else $error("doubler flag wrong");
  lock_win_a: assert property (!$past(rst) |-> lock_window == lw(
    $past({word6[LOCK_HI_BIT], word6[LOCK_MID_BIT], word2[LOCK_BASE_BIT]})))
    else $error("lock window wrong");
  // ----------------------------------------
  // Phase detector
  // ----------------------------------------
  pfd_up_a: assert property (
    $rose(ref_edge) && !pd_up && !pd_dn |-> ##3 pd_up)
    else $error("detector up late");
  pfd_clear_a: assert property (pd_up && pd_dn |=> !pd_up && !pd_dn)
    else $error("detector outputs not cleared");
endmodule
bind fnd_core fnd_core_chk i_fnd_core_chk (.*);
`default_nettype wire

// file: testbench/fnd_host.sv
// Host model that programs the divider configuration words
`timescale 1ns/1ps
`default_nettype none
module fnd_host
  import fnd_pkg::*;
(
  input wire logic mclk, // Block clock
  input wire fnd_pkg::fnd_ratio_t ratio, // Requested divide setting
  input wire logic load, // Request a word 0 write
  input wire logic skip, // Skip band select bit
  output logic [31:0] word0, // Configuration word 0
  output logic [31:0] word1, // Configuration word 1
  output logic ext_en, // Upper bits in use
  output logic [3:0] num_upper, // Numerator upper bits
  output logic [3:0] denominator_upper_bits, // Denominator upper bits
  output var logic word0_wr // Word 0 write strobe
);
  fnd_ratio_t r;
  // Keep numerator and denominator legal
  always_comb begin
    r = ratio;
    if (r.den < 16'h0002) r.den = 16'h0002;
    if (r.num >= r.den) r.num = r.den - 16'h0001;
  end
  // Split the setting across the words
  assign ext_en = (r.num[15:12] != 4'h0) || (r.den[15:12] != 4'h0);
  assign num_upper = r.num[15:12];
  assign denominator_upper_bits = r.den[15:12];
  assign word0 = {1'b0, r.whole, r.num[11:0], 3'h0};
  assign word1 = {3'h0, skip, 13'h0000, r.den[11:0], 3'h0};
  // Strobe follows the request directly, not registered on a clock edge
  assign word0_wr = load;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking testbench of the divider control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fnd_pkg::*;
  logic mclk, rst, ce, load, skip, ref_half, doubler_en, dither_en;
  logic ref_edge, fb_edge, resync_en, word0_wr, ext_en;
  logic int_mode, ref_mult, band_busy, resync_req, pd_up, pd_dn;
  logic [31:0] word0, word1, word2, word4, word6;
  logic [3:0] num_upper, den_up;
  logic [9:0] ref_div;
  logic [15:0] fb_div;
  logic [11:0] band_div;
  logic [7:0] lock_window;
  logic [10:0] pre_div;
  logic [23:0] repeat_len;
  fnd_ratio_t ratio;
  int miscompares = 0;
  int checks_done = 0;
  fnd_host i_fnd_host (.mclk(mclk), .ratio(ratio), .load(load), .skip(skip),
    .word0(word0), .word1(word1), .ext_en(ext_en), .num_upper(num_upper),
    .denominator_upper_bits(den_up), .word0_wr(word0_wr));
  fnd_core i_fnd_core (.mclk(mclk), .rst(rst), .ce(ce), .word0(word0),
    .word0_wr(word0_wr), .word1(word1), .word2(word2), .word4(word4),
    .word6(word6), .ext_en(ext_en), .num_upper(num_upper),
    .denominator_upper_bits(den_up), .ref_div(ref_div),
    .ref_half(ref_half), .doubler_en(doubler_en), .dither_en(dither_en),
    .ref_edge(ref_edge), .fb_edge(fb_edge), .resync_en(resync_en),
    .fb_div(fb_div), .int_mode(int_mode), .band_div(band_div),
    .lock_window(lock_window), .pre_div(pre_div), .ref_mult(ref_mult),
    .repeat_len(repeat_len), .band_busy(band_busy),
    .resync_req(resync_req), .pd_up(pd_up), .pd_dn(pd_dn));
  // Compare and count
  task chk(input string n, input logic [23:0] e, input logic [23:0] s);
    checks_done++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task set_r(input logic [15:0] w, input logic [15:0] n, input logic [15:0] d);
    ratio = '{w, n, d};
    step(3);
  endtask
  task t_ratio();
    logic [23:0] sum;
    set_r(16'h0064, 16'h0000, 16'h0007);
    chk("int_mode", 24'h1, {23'h0, int_mode});
    chk("fb_div", 24'h64, {8'h0, fb_div});
    set_r(16'h0064, 16'h0003, 16'h0007);
    chk("int_mode", 24'h0, {23'h0, int_mode});
    sum = 24'h0;
    repeat (7) begin sum = sum + fb_div; step(1); end
    chk("sum", 24'd703, sum);
    set_r(16'h0010, 16'h1000, 16'h1001);
    chk("int_mode", 24'h0, {23'h0, int_mode});
    sum = 24'h0;
    repeat (4097) begin sum = sum + fb_div; step(1); end
    chk("sum", 24'd69648, sum);
  endtask
  task t_repeat();
    logic [15:0] d[4] = '{16'h0004, 16'h0009, 16'h000C, 16'h0007};
    logic [23:0] e[4] = '{24'h8, 24'h1B, 24'h48, 24'h7};
    for (int i = 0; i < 4; i++) begin
      set_r(16'h0064, 16'h0001, d[i]);
      chk("repeat_len", e[i], repeat_len);
    end
    dither_en = 1'b1;
    step(3);
    chk("repeat_len", 24'h20_0000, repeat_len);
    dither_en = 1'b0;
  endtask
  task t_lock();
    logic [7:0] e[8] = '{LW_10_0, LW_6_0, LW_3_0, LW_3_0, LW_4_0, LW_4_5,
      LW_1_5, LW_1_5};
    for (int c = 0; c < 8; c++) begin
      {word6[27], word6[26], word2[7]} = c[2:0];
      step(3);
      chk("lock_window", {16'h0, e[c]}, {16'h0, lock_window});
    end
  endtask
  task t_ref();
    ref_div = 10'h3FF; ref_half = 1'b1; doubler_en = 1'b1;
    word6[6:3] = 4'hA; word4[10:3] = 8'h5C;
    step(3);
    chk("pre_div", 24'h7FE, {13'h0, pre_div});
    chk("ref_mult", 24'h1, {23'h0, ref_mult});
    chk("band_div", 24'hA5C, {12'h0, band_div});
    ref_half = 1'b0; doubler_en = 1'b0; word6[6:3] = 4'h0;
    step(3);
    chk("pre_div", 24'h3FF, {13'h0, pre_div});
    chk("ref_mult", 24'h0, {23'h0, ref_mult});
    chk("band_div", 24'h05C, {12'h0, band_div});
    // Clock enable low freezes the settings
    ce = 1'b0;
    word4[10:3] = 8'h33;
    step(3);
    chk("band_div", 24'h05C, {12'h0, band_div});
    ce = 1'b1;
    step(2);
    chk("band_div", 24'h033, {12'h0, band_div});
  endtask
  task t_band();
    int nb, nr;
    skip = 1'b1; load = 1'b1; step(1); load = 1'b0; step(4);
    chk("band_busy", 24'h0, {23'h0, band_busy});
    skip = 1'b0; resync_en = 1'b1; nb = 0; nr = 0;
    load = 1'b1;
    // Second strobe lands while busy and is refused
    for (int i = 0; i < 200; i++) begin
      step(1);
      load = (i == 10);
      if (band_busy === 1'b1) nb++;
      if (resync_req === 1'b1) nr++;
    end
    chk("busy cycles", 24'd64, nb[23:0]);
    chk("resync pulses", 24'd1, nr[23:0]);
  endtask
  task t_pfd();
    ref_edge = 1'b1; step(4);
    chk("pd_up", 24'h1, {23'h0, pd_up});
    chk("pd_dn", 24'h0, {23'h0, pd_dn});
    fb_edge = 1'b1; step(6);
    chk("pd both", 24'h0, {22'h0, pd_up, pd_dn});
    ref_edge = 1'b0; fb_edge = 1'b0; step(4);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Clock at 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1; ce = 1'b1; load = 1'b0; skip = 1'b0; ref_half = 1'b0;
    doubler_en = 1'b0; dither_en = 1'b0; ref_edge = 1'b0; fb_edge = 1'b0;
    resync_en = 1'b0; word2 = 32'h0000_0000; word4 = 32'h0000_0000;
    word6 = 32'h0000_0000; ref_div = 10'h001;
    ratio = '{16'h0064, 16'h0000, 16'h0007};
    step(16);
    rst = 1'b0;
    step(80);
    t_ratio();
    t_repeat();
    t_lock();
    t_ref();
    t_band();
    t_pfd();
    finish_test();
  end
endmodule
`default_nettype wire
